//--- core/ivp_pkg.sv
// shared constants and carrier types of the interrupt vector controller
package ivp_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int VADDR_W = 24;
  localparam int VEC_W = 7;

  // register word indices
  localparam logic [ADDR_W-1:0] REG_CTRL1  = 6'h00;
  localparam logic [ADDR_W-1:0] REG_CTRL2  = 6'h01;
  localparam logic [ADDR_W-1:0] REG_FLAG0  = 6'h02;
  localparam logic [ADDR_W-1:0] REG_ENAB0  = 6'h07;
  localparam logic [ADDR_W-1:0] REG_PRIO0  = 6'h0C;
  localparam logic [ADDR_W-1:0] REG_STATUS = 6'h1E;
  localparam logic [ADDR_W-1:0] REG_CORE   = 6'h1F;

  localparam int FLAG_REGS         = 5;
  localparam int PRIO_REGS_FULL    = 18;
  localparam int PRIO_REGS_REDUCED = 17;
  localparam int NUM_SRC           = 72;
  localparam int PRIO_PER_REG      = 4;
  localparam int PRIO_FIELD_W      = 3;

  localparam logic [DATA_W-1:0] RESET_WORD = 16'h0000;
  localparam logic [DATA_W-1:0] PRIO_MASK  = 16'h7777;

  // field positions
  localparam int NEST_DIS_BIT  = 15;
  localparam int TRAP_FLAG_LSB = 1;
  localparam int NUM_TRAPS     = 5;
  localparam int ALT_TABLE_BIT = 15;
  localparam int EXT_POL_LSB   = 0;
  localparam int NUM_EXT       = 5;
  localparam int LEVEL_LSB     = 5;
  localparam int LEVEL_TOP_BIT = 3;

  // request numbers of the external inputs
  localparam int EXT_IRQ_NUM [NUM_EXT] = '{0, 20, 29, 53, 54};

  // vector layout
  localparam logic [VEC_W-1:0]   IRQ_VEC_BASE   = 7'h08;
  localparam logic [VEC_W-1:0]   TRAP_VEC_FIRST = 7'h01;
  localparam logic [VADDR_W-1:0] TABLE_BASE     = 24'h000004;
  localparam logic [VADDR_W-1:0] ALT_OFFSET     = 24'h000100;
  localparam logic [2:0]         LEVEL_BLOCK    = 3'h7;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ivp_bus_s;

  typedef struct packed {
    logic               valid;
    logic               trap;
    logic [VEC_W-1:0]   vector;
    logic [VADDR_W-1:0] addr;
    logic [2:0]         prio;
  } ivp_req_s;

endpackage : ivp_pkg

//--- core/ivp_prio_store.sv
// priority word store with registered read port and parallel view
`timescale 1ns/1ps
module ivp_prio_store
  import ivp_pkg::*;
#(
  parameter int DEPTH = PRIO_REGS_FULL
) (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  // write port
  input  wire logic                    wrEn,
  input  wire logic [4:0]              wrIdx,
  input  wire logic [DATA_W-1:0]       wrData,
  // read port
  input  wire logic [4:0]              rdIdx,
  output logic      [DATA_W-1:0]       rdData,
  // all words for the arbiter
  output logic      [DEPTH*DATA_W-1:0] words
);

  logic [DATA_W-1:0] mem      [DEPTH];
  logic [DATA_W-1:0] next_mem [DEPTH];
  logic [DATA_W-1:0] next_rdData;

  always_comb begin
    next_rdData = RESET_WORD;
    for (int i = 0; i < DEPTH; i++) begin
      next_mem[i] = mem[i];
      if (wrEn && (int'(wrIdx) == i)) begin
        next_mem[i] = wrData & PRIO_MASK;
      end
      if (int'(rdIdx) == i) begin
        next_rdData = mem[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= RESET_WORD;
      end
      rdData <= RESET_WORD;
    end else begin
      mem    <= next_mem;
      rdData <= next_rdData;
    end
  end

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      words[i*DATA_W +: DATA_W] = mem[i];
    end
  end

endmodule : ivp_prio_store

//--- core/ivp_ctrl.sv
// interrupt and trap controller: flags, enables, priorities, vectors
//
// Contract
// - request n uses vector n+8 at address 4+2*vector, alternate 0x100 higher
// - eight trap vectors from 0x000004; traps 1..5 are oscillator to DMA error
// - thirty interrupt control registers, twenty-nine without the last priority
// - first global control holds nesting disable and all trap flags
// - second global control sets external input edges and alternate table
// - each source has a flag set by its source, cleared only by software
// - a source is serviced only while its enable bit is set
// - each user source has a programmable three-bit priority, eight levels; reduced, sources 68..71 are fixed at priority 0
// - flag, enable and priority fields follow request number order
// - status word bits 7:5 hold low cpu level, software writable
// - top cpu level bit in core control is read-only to software
// - cpu level is the top bit joined above the three status bits
// - top level bit set blocks all user sources and all traps, nothing served
// - status level 111 blocks all user interrupts
// - status level bits read-only while nesting is disabled
`timescale 1ns/1ps
module ivp_ctrl
  import ivp_pkg::*;
#(
  parameter int NUM_PRIO_REGS = PRIO_REGS_FULL
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  // register port
  input  wire ivp_bus_s             regBus,
  output logic      [DATA_W-1:0]    regRdata,
  // event sources
  input  wire logic [NUM_SRC-1:0]   srcEvent,
  input  wire logic [NUM_TRAPS-1:0] trapEvent,
  input  wire logic [NUM_EXT-1:0]   extPin,
  // core side
  output ivp_req_s                  req,
  input  wire logic                 irqAck,
  input  wire logic                 cpuLevelLoad,
  input  wire logic [3:0]           cpuLevelIn
);

  localparam int FLAG_W = FLAG_REGS * DATA_W;

  if (NUM_PRIO_REGS != PRIO_REGS_FULL &&
      NUM_PRIO_REGS != PRIO_REGS_REDUCED) begin : g_bad_prio
    $error("ivp_ctrl: priority register count not supported");
  end
  if (NUM_SRC > FLAG_W) begin : g_bad_src
    $error("ivp_ctrl: more sources than flag bits");
  end

  // table address of a vector, primary or alternate
  function automatic logic [VADDR_W-1:0] vecAddr(
    input logic [VEC_W-1:0] vec,
    input logic             alt
  );
    logic [VADDR_W-1:0] a;
    a = TABLE_BASE + {16'h0000, vec, 1'b0};
    if (alt) begin
      a = a + ALT_OFFSET;
    end
    return a;
  endfunction : vecAddr

  // register state
  logic                 nestDis;
  logic [NUM_TRAPS-1:0] trapFlag;
  logic                 altTable;
  logic [NUM_EXT-1:0]   extFalling;
  logic [FLAG_W-1:0]    flags;
  logic [FLAG_W-1:0]    enables;
  logic [2:0]           levelLow;
  logic                 levelTop;
  logic                 next_nestDis;
  logic [NUM_TRAPS-1:0] next_trapFlag;
  logic                 next_altTable;
  logic [NUM_EXT-1:0]   next_extFalling;
  logic [FLAG_W-1:0]    next_flags;
  logic [FLAG_W-1:0]    next_enables;
  logic [2:0]           next_levelLow;
  logic                 next_levelTop;

  // external input synchroniser and edge detect
  logic [NUM_EXT-1:0] extSync1;
  logic [NUM_EXT-1:0] extSync2;
  logic [NUM_EXT-1:0] extPrev;
  logic [NUM_EXT-1:0] extEdge;

  // read path and arbitration result
  logic [DATA_W-1:0]             rdWord;
  logic                          rdFromStore;
  ivp_req_s                      next_req;
  logic [DATA_W-1:0]             next_rdWord;
  logic                          next_rdFromStore;
  logic [NUM_PRIO_REGS*DATA_W-1:0] prioWords;
  logic [DATA_W-1:0]             storeRdata;
  logic                          prioWr;
  logic [4:0]                    prioIdx;
  logic                          inPrio;

  // priority word window, one word shorter when reduced
  always_comb begin
    inPrio  = (regBus.addr >= REG_PRIO0) &&
              (regBus.addr < REG_PRIO0 + ADDR_W'(NUM_PRIO_REGS));
    prioIdx = 5'(regBus.addr - REG_PRIO0);
    prioWr  = regBus.wr && inPrio;
  end

  ivp_prio_store #(
    .DEPTH (NUM_PRIO_REGS)
  ) u_prio (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wrEn    (prioWr),
    .wrIdx   (prioIdx),
    .wrData  (regBus.wdata),
    .rdIdx   (prioIdx),
    .rdData  (storeRdata),
    .words   (prioWords)
  );

  always_comb begin
    for (int e = 0; e < NUM_EXT; e++) begin
      extEdge[e] = extFalling[e] ? (extPrev[e] & ~extSync2[e])
                                 : (~extPrev[e] & extSync2[e]);
    end
  end

  // register writes and hardware sets
  always_comb begin
    logic [FLAG_W-1:0] setVec;
    logic [FLAG_W-1:0] clrVec;
    logic [FLAG_W-1:0] implMask;
    setVec   = '0;
    clrVec   = '0;
    implMask = '0;
    implMask[NUM_SRC-1:0] = '1;
    setVec[NUM_SRC-1:0]   = srcEvent;
    for (int e = 0; e < NUM_EXT; e++) begin
      setVec[EXT_IRQ_NUM[e]] = setVec[EXT_IRQ_NUM[e]] | extEdge[e];
    end
    next_nestDis    = nestDis;
    next_altTable   = altTable;
    next_extFalling = extFalling;
    next_enables    = enables;
    next_trapFlag   = trapFlag | trapEvent;
    if (regBus.wr && regBus.addr == REG_CTRL1) begin
      next_nestDis  = regBus.wdata[NEST_DIS_BIT];
      next_trapFlag = (trapFlag &
        ~regBus.wdata[TRAP_FLAG_LSB +: NUM_TRAPS]) | trapEvent;
    end
    if (regBus.wr && regBus.addr == REG_CTRL2) begin
      next_altTable   = regBus.wdata[ALT_TABLE_BIT];
      next_extFalling = regBus.wdata[EXT_POL_LSB +: NUM_EXT];
    end
    for (int w = 0; w < FLAG_REGS; w++) begin
      if (regBus.wr && regBus.addr == REG_FLAG0 + ADDR_W'(w)) begin
        clrVec[w*DATA_W +: DATA_W] = regBus.wdata;
      end
      if (regBus.wr && regBus.addr == REG_ENAB0 + ADDR_W'(w)) begin
        next_enables[w*DATA_W +: DATA_W] = regBus.wdata;
      end
    end
    next_flags   = ((flags & ~clrVec) | setVec) & implMask;
    next_enables = next_enables & implMask;
    // cpu level: core load, then acknowledge, then software
    next_levelLow = levelLow;
    next_levelTop = levelTop;
    if (cpuLevelLoad) begin
      next_levelTop = cpuLevelIn[LEVEL_TOP_BIT];
      next_levelLow = cpuLevelIn[2:0];
    end else if (irqAck && req.valid) begin
      if (req.trap) begin
        next_levelTop = 1'b1;
      end else begin
        next_levelLow = req.prio;
      end
    end else if (regBus.wr && regBus.addr == REG_STATUS && !nestDis) begin
      next_levelLow = regBus.wdata[LEVEL_LSB +: 3];
    end
  end

  // arbitration
  always_comb begin
    logic [2:0]       bestPrio;
    logic [VEC_W-1:0] bestIdx;
    logic             found;
    logic [2:0]       p;
    logic             trapFound;
    logic [VEC_W-1:0] trapIdx;
    logic [VEC_W-1:0] vec;
    bestPrio  = 3'h0;
    bestIdx   = '0;
    found     = 1'b0;
    trapFound = 1'b0;
    trapIdx   = '0;
    p         = 3'h0;
    vec       = '0;
    // downward scan: on a tie the lower request stays
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (i / PRIO_PER_REG < NUM_PRIO_REGS) begin
        p = prioWords[i*PRIO_PER_REG +: PRIO_FIELD_W];
      end else begin
        p = 3'h0;
      end
      if (flags[i] && enables[i] &&
          !levelTop &&
          levelLow != LEVEL_BLOCK &&
          p > levelLow && (!found || p >= bestPrio)) begin
        found    = 1'b1;
        bestPrio = p;
        bestIdx  = VEC_W'(i);
      end
    end
    // traps beat users; the lowest trap index wins
    for (int t = NUM_TRAPS - 1; t >= 0; t--) begin
      if (trapFlag[t] && !levelTop) begin
        trapFound = 1'b1;
        trapIdx   = VEC_W'(t);
      end
    end
    vec = trapFound ? trapIdx + TRAP_VEC_FIRST
                    : bestIdx + IRQ_VEC_BASE;
    next_req.valid  = !irqAck && (trapFound || found);
    next_req.trap   = trapFound;
    next_req.vector = vec;
    next_req.addr   = vecAddr(vec, altTable);
    next_req.prio   = trapFound ? LEVEL_BLOCK : bestPrio;
  end

  // read decode
  // unmapped indices and idle cycles give zero
  always_comb begin
    next_rdWord      = RESET_WORD;
    next_rdFromStore = regBus.rd && inPrio;
    if (regBus.rd) begin
      if (regBus.addr == REG_CTRL1) begin
        next_rdWord[NEST_DIS_BIT] = nestDis;
        next_rdWord[TRAP_FLAG_LSB +: NUM_TRAPS] = trapFlag;
      end
      if (regBus.addr == REG_CTRL2) begin
        next_rdWord[ALT_TABLE_BIT] = altTable;
        next_rdWord[EXT_POL_LSB +: NUM_EXT] = extFalling;
      end
      for (int w = 0; w < FLAG_REGS; w++) begin
        if (regBus.addr == REG_FLAG0 + ADDR_W'(w)) begin
          next_rdWord = flags[w*DATA_W +: DATA_W];
        end
        if (regBus.addr == REG_ENAB0 + ADDR_W'(w)) begin
          next_rdWord = enables[w*DATA_W +: DATA_W];
        end
      end
      if (regBus.addr == REG_STATUS) begin
        next_rdWord[LEVEL_LSB +: 3] = levelLow;
      end
      if (regBus.addr == REG_CORE) begin
        next_rdWord[LEVEL_TOP_BIT] = levelTop;
      end
    end
  end

  // priority words come from the store's own register
  always_comb begin
    regRdata = rdFromStore ? storeRdata : rdWord;
  end

  // every state register, synchronous reset to zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      nestDis     <= 1'b0;
      trapFlag    <= '0;
      altTable    <= 1'b0;
      extFalling  <= '0;
      flags       <= '0;
      enables     <= '0;
      levelLow    <= 3'h0;
      levelTop    <= 1'b0;
      extSync1    <= '0;
      extSync2    <= '0;
      extPrev     <= '0;
      req         <= '0;
      rdWord      <= RESET_WORD;
      rdFromStore <= 1'b0;
    end else begin
      nestDis     <= next_nestDis;
      trapFlag    <= next_trapFlag;
      altTable    <= next_altTable;
      extFalling  <= next_extFalling;
      flags       <= next_flags;
      enables     <= next_enables;
      levelLow    <= next_levelLow;
      levelTop    <= next_levelTop;
      extSync1    <= extPin;
      extSync2    <= extSync1;
      extPrev     <= extSync2;
      req         <= next_req;
      rdWord      <= next_rdWord;
      rdFromStore <= next_rdFromStore;
    end
  end

endmodule : ivp_ctrl

//--- verification/ivp_ctrl_checker.sv
// port assertions for the interrupt vector controller
`timescale 1ns/1ps
module ivp_ctrl_checker
  import ivp_pkg::*;
#(
  parameter int NUM_PRIO_REGS = PRIO_REGS_FULL
) (
  // clock and reset
  input wire logic                 sys_clk,
  input wire logic                 rst_n,
  // register port
  input wire ivp_bus_s             regBus,
  input wire logic [DATA_W-1:0]    regRdata,
  // event sources
  input wire logic [NUM_SRC-1:0]   srcEvent,
  input wire logic [NUM_TRAPS-1:0] trapEvent,
  input wire logic [NUM_EXT-1:0]   extPin,
  // core side
  input wire ivp_req_s             req,
  input wire logic                 irqAck,
  input wire logic                 cpuLevelLoad,
  input wire logic [3:0]           cpuLevelIn
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_ack;
    irqAck && req.valid;
  endsequence
  sequence s_userQuiet;
    !(req.valid && !req.trap);
  endsequence

  property p_addr;
    req.valid |-> req.addr[7:0] == 8'(4 + 2 * req.vector)
      && req.addr[23:9] == '0;
  endproperty
  property p_trapVec;
    req.valid && req.trap |-> req.vector inside {[1:5]};
  endproperty
  property p_userVec;
    req.valid && !req.trap |-> req.vector inside {[8:79]};
  endproperty
  property p_blank;
    s_ack |=> !req.valid;
  endproperty
  property p_trapAck;
    s_ack ##0 req.trap |=> (!req.valid) [*3];
  endproperty
  property p_top;
    cpuLevelLoad && cpuLevelIn[3] |-> ##2 s_userQuiet [*2];
  endproperty
  property p_lvl7;
    cpuLevelLoad && cpuLevelIn[2:0] == LEVEL_BLOCK |-> ##2 s_userQuiet [*2];
  endproperty
  property p_core;
    regBus.rd && regBus.addr == REG_CORE
      |=> regRdata[15:4] == '0 && regRdata[2:0] == '0;
  endproperty
  property p_prio;
    regBus.rd && regBus.addr >= REG_PRIO0
      && regBus.addr < REG_PRIO0 + NUM_PRIO_REGS
      |=> (regRdata & ~PRIO_MASK) == '0;
  endproperty

  a_addr: assert property (p_addr)
    else $error("vector address wrong");
  a_trapVec: assert property (p_trapVec)
    else $error("trap vector out of range");
  a_userVec: assert property (p_userVec)
    else $error("user vector out of range");
  a_blank: assert property (p_blank)
    else $error("request not blanked after ack");
  a_trapAck: assert property (p_trapAck)
    else $error("request after trap ack");
  a_top: assert property (p_top)
    else $error("user request with top level bit");
  a_lvl7: assert property (p_lvl7)
    else $error("user request at level seven");
  a_core: assert property (p_core)
    else $error("core word stray bits");
  a_prio: assert property (p_prio)
    else $error("priority word stray bits");
endmodule : ivp_ctrl_checker

bind ivp_ctrl ivp_ctrl_checker #(.NUM_PRIO_REGS(NUM_PRIO_REGS)) i_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .regBus(regBus), .regRdata(regRdata),
  .srcEvent(srcEvent), .trapEvent(trapEvent), .extPin(extPin), .req(req),
  .irqAck(irqAck), .cpuLevelLoad(cpuLevelLoad), .cpuLevelIn(cpuLevelIn)
);

//--- verification/ivp_core_model.sv
// behavioural core: acknowledges requests and loads the cpu level
`timescale 1ns/1ps
module ivp_core_model
  import ivp_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // controller side
  input  wire ivp_req_s   req,
  output logic            irqAck,
  output logic            cpuLevelLoad,
  output logic [3:0]      cpuLevelIn,
  // bench control
  input  wire logic       ackEn,
  input  wire logic       slow,
  input  wire logic       setLvl,
  input  wire logic [3:0] lvlVal,
  output ivp_req_s        taken,
  output logic [7:0]      ackCnt
);
  logic [1:0] dly;
  always_ff @(posedge sys_clk) begin
    cpuLevelLoad <= setLvl;
    cpuLevelIn   <= lvlVal;
    irqAck       <= 1'b0;
    if (!rst_n) begin
      dly    <= '0;
      ackCnt <= '0;
      taken  <= '0;
    end else if (irqAck && req.valid) begin
      taken  <= req;
      ackCnt <= ackCnt + 8'h01;
      dly    <= '0;
    end else if (req.valid && ackEn && !irqAck) begin
      irqAck <= dly == (slow ? 2'h3 : 2'h0);
      dly    <= dly + 2'h1;
    end else if (!req.valid) begin
      dly <= '0;
    end
  end
endmodule : ivp_core_model

//--- verification/ivp_ctrl_tb_top.sv
// self-checking bench for the interrupt vector controller
`timescale 1ns/1ps
module ivp_ctrl_tb_top
  import ivp_pkg::*;
;
  logic               sys_clk = 1'b0;
  logic               rst_n = 1'b0;
  ivp_bus_s           bus = '0;
  logic [DATA_W-1:0]  rdata;
  logic [NUM_SRC-1:0] src = '0;
  logic [4:0]         trap = '0;
  logic [4:0]         ext = '0;
  ivp_req_s           req;
  ivp_req_s           taken;
  logic               ack;
  logic               load;
  logic [3:0]         lvlIn;
  logic               ackEn = 1'b0;
  logic               slow = 1'b0;
  logic               setLvl = 1'b0;
  logic [3:0]         lvlVal = '0;
  logic [7:0]         ackCnt;
  int                 failCount = 0;
  int                 samplesChecked = 0;
  localparam logic [5:0] RST_REGS [8] = '{REG_CTRL1, REG_CTRL2, REG_FLAG0,
    REG_ENAB0, REG_PRIO0, REG_STATUS, REG_CORE, 6'h3F};

  always #4 sys_clk = ~sys_clk;

  ivp_ctrl i_ivp_ctrl (.sys_clk(sys_clk), .rst_n(rst_n), .regBus(bus),
    .regRdata(rdata), .srcEvent(src), .trapEvent(trap), .extPin(ext),
    .req(req), .irqAck(ack), .cpuLevelLoad(load), .cpuLevelIn(lvlIn));
  ivp_core_model i_ivp_core_model (.sys_clk(sys_clk), .rst_n(rst_n),
    .req(req), .irqAck(ack), .cpuLevelLoad(load), .cpuLevelIn(lvlIn),
    .ackEn(ackEn), .slow(slow), .setLvl(setLvl), .lvlVal(lvlVal),
    .taken(taken), .ackCnt(ackCnt));

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failCount++;
      $display("MISMATCH %s exp %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(logic [5:0] a, logic [15:0] d);
    @(posedge sys_clk) bus <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk) bus <= '0;
  endtask : wr

  task automatic rd(logic [5:0] a, logic [15:0] e);
    @(posedge sys_clk) bus <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge sys_clk) bus <= '0;
    #1 check("rdata", 32'(rdata), 32'(e));
  endtask : rd

  task automatic ev(int n);
    @(posedge sys_clk);
    if (n < NUM_SRC) src[n] <= 1'b1;
    else trap[n-NUM_SRC] <= 1'b1;
    @(posedge sys_clk);
    src <= '0;
    trap <= '0;
  endtask : ev

  task automatic lvl(logic [3:0] v);
    @(posedge sys_clk) setLvl <= 1'b1;
    lvlVal <= v;
    @(posedge sys_clk) setLvl <= 1'b0;
  endtask : lvl

  task automatic serve(logic t, logic [6:0] v, logic [23:0] a);
    logic [7:0] c;
    c = ackCnt;
    repeat (40) if (ackCnt == c) @(posedge sys_clk);
    check("taken", {taken.trap, taken.vector, taken.addr}, {t, v, a});
  endtask : serve

  task automatic quiet();
    repeat (4) @(posedge sys_clk);
    #1 check("valid", 32'(req.valid), 32'h0);
  endtask : quiet

  task automatic print_verdict();
    if (failCount == 0 && samplesChecked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    wr(6'h3F, 16'hFFFF);
    foreach (RST_REGS[i]) rd(RST_REGS[i], 16'h0000);
    wr(REG_PRIO0 + 6'h11, 16'hFFFF);
    rd(REG_PRIO0 + 6'h11, 16'h7777);
    ev(17);
    rd(REG_FLAG0 + 6'h01, 16'h0002);
    wr(REG_FLAG0 + 6'h01, 16'h0000);
    rd(REG_FLAG0 + 6'h01, 16'h0002);
    wr(REG_FLAG0 + 6'h01, 16'h0002);
    rd(REG_FLAG0 + 6'h01, 16'h0000);
    @(posedge sys_clk) ext[1] <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(REG_FLAG0 + 6'h01, 16'h0010);
    wr(REG_FLAG0 + 6'h01, 16'h0010);
    wr(REG_CTRL2, 16'h0002);
    rd(REG_CTRL2, 16'h0002);
    @(posedge sys_clk) ext[1] <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rd(REG_FLAG0 + 6'h01, 16'h0010);
    wr(REG_FLAG0 + 6'h01, 16'h0010);
    wr(REG_PRIO0, 16'h4000);
    wr(REG_PRIO0 + 6'h01, 16'h0064);
    wr(REG_ENAB0, 16'h0038);
    for (int n = 3; n < 6; n++) ev(n);
    ackEn <= 1'b1;
    serve(1'b0, 7'h0D, 24'h00001E);
    rd(REG_STATUS, 16'h00C0);
    wr(REG_FLAG0, 16'h0020);
    slow <= 1'b1;
    lvl(4'h0);
    serve(1'b0, 7'h0B, 24'h00001A);
    wr(REG_FLAG0, 16'h0008);
    lvl(4'h0);
    serve(1'b0, 7'h0C, 24'h00001C);
    wr(REG_FLAG0, 16'h0010);
    wr(REG_CTRL2, 16'h8000);
    wr(REG_ENAB0 + 6'h04, 16'h0080);
    lvl(4'h0);
    ev(71);
    serve(1'b0, 7'h4F, 24'h0001A2);
    wr(REG_FLAG0 + 6'h04, 16'h0080);
    ev(NUM_SRC + 2);
    serve(1'b1, 7'h03, 24'h00010A);
    rd(REG_CORE, 16'h0008);
    wr(REG_CORE, 16'h0000);
    rd(REG_CORE, 16'h0008);
    rd(REG_CTRL1, 16'h0008);
    wr(REG_CTRL1, 16'h0008);
    wr(REG_CTRL2, 16'h0000);
    for (int t = 0; t < 5; t++) begin
      lvl(4'h0);
      ev(NUM_SRC + t);
      serve(1'b1, 7'(t + 1), 24'(6 + 2 * t));
      wr(REG_CTRL1, 16'(2 << t));
    end
    lvl(4'h0);
    wr(REG_CTRL1, 16'h8000);
    wr(REG_STATUS, 16'h00E0);
    rd(REG_STATUS, 16'h0000);
    wr(REG_CTRL1, 16'h0000);
    wr(REG_STATUS, 16'h00E0);
    rd(REG_STATUS, 16'h00E0);
    ev(5);
    quiet();
    wr(REG_STATUS, 16'h00A0);
    serve(1'b0, 7'h0D, 24'h00001E);
    wr(REG_FLAG0, 16'h0020);
    lvl(4'h7);
    ev(3);
    quiet();
    lvl(4'h8);
    quiet();
    wr(REG_ENAB0, 16'h0000);
    lvl(4'h0);
    quiet();
    wr(REG_ENAB0, 16'h0008);
    serve(1'b0, 7'h0B, 24'h00001A);
    wr(REG_FLAG0, 16'h0008);
    print_verdict();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    failCount++;
    print_verdict();
  end
endmodule : ivp_ctrl_tb_top
